// ==== tsp_port.v ====
// Two-wire serial slave port and register file of the temperature sensor.
`timescale 1ns/1ps
`include "tsp_map.vh"
module tsp_port #(
  parameter [6:0] SLAVE_ADDR = `TSP_SLAVE_ADDR,
  parameter TIMEOUT_EN = 1,
  parameter TIMEOUT_CYC = `TSP_TIMEOUT_CYC,
  parameter FILT_CYC = `TSP_FILT_CYC,
  parameter RST_CYC = `TSP_RST_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe_n,
  input wire reset_pin_n,
  input wire [8:0] temp_data,
  input wire temp_update,
  input wire comp_hot,
  input wire comp_event,
  output reg over_temp_alarm_output,
  output wire shutdown,
  output wire [1:0] fault_queue_sel,
  output wire interrupt_mode,
  output wire alarm_polarity
);
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_ADDR_ACK = 4'h2;
  localparam ST_PTR = 4'h3;
  localparam ST_PTR_ACK = 4'h4;
  localparam ST_WDATA = 4'h5;
  localparam ST_WDATA_ACK = 4'h6;
  localparam ST_RDATA = 4'h7;
  localparam ST_RACK = 4'h8;

  wire scl_f;
  wire sda_f;
  wire pin_rst_f;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [3:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] rx_reg;
  reg [7:0] tx_reg;
  reg [1:0] byte_reg;
  reg rw_reg;
  reg mack_reg;
  reg [1:0] ptr_reg;
  reg [4:0] cfg_reg;
  reg [8:0] thyst_reg;
  reg [8:0] tos_reg;
  reg [8:0] temp_reg;
  reg [8:0] snap_reg;
  reg alarm_reg;
  reg [24:0] tmo_reg;
  reg [15:0] rd_word;

  // Both bus lines and the reset pin are synchronised and filtered.
  tsp_filter #(.LEN(FILT_CYC), .CW(8), .INIT(1'b1)) u_scl_filt (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(scl_in),
    .level_out(scl_f)
  );
  tsp_filter #(.LEN(FILT_CYC), .CW(8), .INIT(1'b1)) u_sda_filt (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(sda_in),
    .level_out(sda_f)
  );
  // A reset pulse counts only once it has stayed low for the minimum width.
  tsp_filter #(.LEN(RST_CYC), .CW(8), .INIT(1'b1)) u_rst_filt (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(reset_pin_n),
    .level_out(pin_rst_f)
  );

  wire scl_rise = scl_f & ~scl_d_reg;
  wire scl_fall = ~scl_f & scl_d_reg;
  wire start_cond = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire stop_cond = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  wire soft_rst = ~pin_rst_f;
  wire bus_tmo = (TIMEOUT_EN != 0) && (tmo_reg >= TIMEOUT_CYC[24:0]);
  wire reading = (state_reg == ST_RDATA) || (state_reg == ST_RACK);

  // The open-drain data pin only ever pulls low.
  assign sda_out = 1'b0;
  assign shutdown = cfg_reg[`TSP_CFG_SHDN];
  assign interrupt_mode = cfg_reg[`TSP_CFG_MODE];
  assign alarm_polarity = cfg_reg[`TSP_CFG_POL];
  assign fault_queue_sel = cfg_reg[`TSP_CFG_FQ_HI:`TSP_CFG_FQ_LO];

  // Word returned for the pointed register; limits read zeros below bit 7.
  always @* begin
    case (ptr_reg)
      `TSP_PTR_TEMP: rd_word = {snap_reg, 7'h00};
      `TSP_PTR_CFG: rd_word = {3'h0, cfg_reg, 3'h0, cfg_reg};
      `TSP_PTR_THYST: rd_word = {thyst_reg, 7'h00};
      default: rd_word = {tos_reg, 7'h00};
    endcase
  end

  // Edge history of the filtered lines and the stuck-low timer.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      tmo_reg <= 25'h0000000;
    end else if (clk_en) begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      // The timer restarts whenever the data line is seen high.
      if (sda_f || soft_rst || bus_tmo) begin
        tmo_reg <= 25'h0000000;
      end else begin
        tmo_reg <= tmo_reg + 1'b1;
      end
    end
  end

  // Temperature capture; conversions landing during a read are dropped so the
  // word on the wire cannot tear, and the next conversion refreshes it.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      temp_reg <= 9'h000;
    end else if (clk_en) begin
      if (soft_rst) begin
        temp_reg <= 9'h000;
      end else if (temp_update && !reading) begin
        temp_reg <= temp_data;
      end
    end
  end

  // Alarm output: comparator mode follows the comparator, interrupt mode latches
  // events until a read; shutdown clears it. Polarity bit picks the sense.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
      over_temp_alarm_output <= 1'b1;
    end else if (clk_en) begin
      if (soft_rst || cfg_reg[`TSP_CFG_SHDN]) begin
        alarm_reg <= 1'b0;
      end else if (!cfg_reg[`TSP_CFG_MODE]) begin
        alarm_reg <= comp_hot;
      end else if (comp_event) begin
        alarm_reg <= 1'b1; // Set wins over a same-cycle read.
      end else if (state_reg == ST_ADDR_ACK && scl_fall && rw_reg) begin
        alarm_reg <= 1'b0;
      end
      over_temp_alarm_output <= cfg_reg[`TSP_CFG_POL] ? alarm_reg : ~alarm_reg;
    end
  end

  // Bus protocol engine and register writes. Bits are sampled on the rising
  // serial clock and driven on the falling one, so data moves while the clock
  // is high only when a bus timeout or the reset pin releases it.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      byte_reg <= 2'h0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_n <= 1'b1;
      ptr_reg <= `TSP_PTR_RESET;
      cfg_reg <= `TSP_CFG_RESET;
      thyst_reg <= `TSP_THYST_RESET;
      tos_reg <= `TSP_TOS_RESET;
      snap_reg <= 9'h000;
    end else if (clk_en) begin
      if (soft_rst) begin
        state_reg <= ST_IDLE;
        sda_oe_n <= 1'b1;
        ptr_reg <= `TSP_PTR_RESET;
        cfg_reg <= `TSP_CFG_RESET;
        thyst_reg <= `TSP_THYST_RESET;
        tos_reg <= `TSP_TOS_RESET;
      end else if (bus_tmo) begin
        state_reg <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_cond) begin
        // A repeated start lands here too and keeps the pointer.
        state_reg <= ST_ADDR;
        bit_reg <= 4'h0;
        byte_reg <= 2'h0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WDATA) begin
          rx_reg <= {rx_reg[6:0], sda_f};
          bit_reg <= bit_reg + 1'b1;
        end else if (state_reg == ST_RDATA) begin
          bit_reg <= bit_reg + 1'b1;
        end else if (state_reg == ST_RACK) begin
          mack_reg <= ~sda_f;
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_reg == 4'h8) begin
              if (rx_reg[7:1] == SLAVE_ADDR) begin
                rw_reg <= rx_reg[0];
                sda_oe_n <= 1'b0;
                state_reg <= ST_ADDR_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_reg <= 4'h0;
            if (rw_reg) begin
              // Address-only read of the pointed register; snapshot now.
              snap_reg <= temp_reg;
              if (ptr_reg == `TSP_PTR_TEMP) begin
                tx_reg <= {temp_reg[7:1], 1'b0};
                sda_oe_n <= temp_reg[8];
              end else begin
                tx_reg <= {rd_word[14:8], 1'b0};
                sda_oe_n <= rd_word[15];
              end
              state_reg <= ST_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              state_reg <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (bit_reg == 4'h8) begin
              ptr_reg <= rx_reg[1:0];
              sda_oe_n <= 1'b0;
              state_reg <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (bit_reg == 4'h8) begin
              sda_oe_n <= 1'b0; // Temperature writes are acked but dropped.
              if (byte_reg != 2'h2) begin
                byte_reg <= byte_reg + 1'b1;
              end
              case (ptr_reg)
                `TSP_PTR_CFG: begin
                  if (byte_reg != 2'h2) begin
                    cfg_reg <= rx_reg[4:0];
                  end
                end
                `TSP_PTR_THYST: begin
                  if (byte_reg == 2'h0) begin
                    thyst_reg <= {rx_reg, 1'b0};
                  end else if (byte_reg == 2'h1) begin
                    thyst_reg[0] <= rx_reg[7];
                  end
                end
                `TSP_PTR_TOS: begin
                  if (byte_reg == 2'h0) begin
                    tos_reg <= {rx_reg, 1'b0};
                  end else if (byte_reg == 2'h1) begin
                    tos_reg[0] <= rx_reg[7];
                  end
                end
                default: begin
                  byte_reg <= byte_reg;
                end
              endcase
              state_reg <= ST_WDATA_ACK;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            sda_oe_n <= 1'b1;
            bit_reg <= 4'h0;
            state_reg <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_reg == 4'h8) begin
              sda_oe_n <= 1'b1; // Data line freed for the master's ack slot.
              state_reg <= ST_RACK;
            end else begin
              sda_oe_n <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            bit_reg <= 4'h0;
            if (mack_reg) begin
              // Bytes alternate high then low for as long as the master acks.
              byte_reg <= byte_reg + 1'b1;
              if (byte_reg[0]) begin
                tx_reg <= {rd_word[14:8], 1'b0};
                sda_oe_n <= rd_word[15];
              end else begin
                tx_reg <= {rd_word[6:0], 1'b0};
                sda_oe_n <= rd_word[7];
              end
              state_reg <= ST_RDATA;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ==== tsp_map.vh ====
// Constants for the temperature sensor serial register port.
`ifndef TSP_MAP_VH
`define TSP_MAP_VH

// Register pointer values.
`define TSP_PTR_TEMP 2'h0
`define TSP_PTR_CFG 2'h1
`define TSP_PTR_THYST 2'h2
`define TSP_PTR_TOS 2'h3

// Power-up values, limits in half-degree steps.
`define TSP_CFG_RESET 5'h00
`define TSP_THYST_RESET 9'h096
`define TSP_TOS_RESET 9'h0A0
`define TSP_PTR_RESET 2'h0

// Configuration field positions.
`define TSP_CFG_SHDN 0
`define TSP_CFG_MODE 1
`define TSP_CFG_POL 2
`define TSP_CFG_FQ_LO 3
`define TSP_CFG_FQ_HI 4

// Timing figures and the clock rate they are counted against.
`define TSP_CLK_MHZ 125
`define TSP_CLK_KHZ 125000
`define TSP_TIMEOUT_MS 250
`define TSP_RST_PULSE_NS 1000
`define TSP_FILT_NS 32
`define TSP_RST_CYC ((`TSP_RST_PULSE_NS * `TSP_CLK_MHZ + 999) / 1000)
`define TSP_FILT_CYC ((`TSP_FILT_NS * `TSP_CLK_MHZ + 999) / 1000)
`define TSP_TIMEOUT_CYC (`TSP_TIMEOUT_MS * `TSP_CLK_KHZ)

// Default seven-bit slave address; arbitrary value.
`define TSP_SLAVE_ADDR 7'h48

`endif

// ==== tsp_filter.v ====
// Synchroniser and stability filter for one asynchronous input pin.
`timescale 1ns/1ps
module tsp_filter #(
  parameter LEN = 4,
  parameter CW = 8,
  parameter INIT = 1'b1
) (
  input wire clock,
  input wire rst_n,
  input wire clk_en,
  input wire pin_in,
  output reg level_out
);
  reg meta_reg;
  reg sync_reg;
  reg [CW-1:0] cnt_reg;

  // Two flops bring the pin into the clock domain; the level then changes only
  // after the new value has held for LEN cycles, which swallows short glitches.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
      cnt_reg <= {CW{1'b0}};
      level_out <= INIT;
    end else if (clk_en) begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      if (sync_reg == level_out) begin
        cnt_reg <= {CW{1'b0}};
      end else if (cnt_reg >= LEN[CW-1:0] - 1'b1) begin
        cnt_reg <= {CW{1'b0}};
        level_out <= sync_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// ==== tsp_port_properties.sv ====
// Concurrent checks on the serial register port pins.
`timescale 1ns/1ps
module tsp_port_properties #(
  parameter TIMEOUT_CYC = 200,
  parameter RST_CYC = 125
) (
  input wire clock,
  input wire rst_n,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire reset_pin_n,
  input wire comp_hot,
  input wire comp_event,
  input wire over_temp_alarm_output,
  input wire shutdown,
  input wire [1:0] fault_queue_sel,
  input wire interrupt_mode,
  input wire alarm_polarity
);
  int low_cnt;
  int rp_cnt;
  // Run lengths of a held data line and of a low reset pin.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
      rp_cnt <= 0;
    end else begin
      low_cnt <= sda_oe_n ? 0 : low_cnt + 1;
      rp_cnt <= reset_pin_n ? 0 : rp_cnt + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_vals_a: assert property ($rose(rst_n) |-> sda_oe_n && over_temp_alarm_output && !shutdown)
    else $error("outputs not idle after reset");
  comp_follow_a: assert property ((!interrupt_mode && !shutdown && reset_pin_n && $stable(comp_hot)
    && $stable(alarm_polarity)) [*4] |-> over_temp_alarm_output == !(comp_hot ^ alarm_polarity))
    else $error("comparator alarm wrong");
  event_set_a: assert property (interrupt_mode && !shutdown && comp_event
    |-> ##[1:3] over_temp_alarm_output == alarm_polarity) else $error("event did not set alarm");
  shdn_clear_a: assert property (interrupt_mode && $rose(shutdown) && !comp_event
    |-> ##[0:2] over_temp_alarm_output != alarm_polarity) else $error("shutdown kept alarm");
  ack_low_a: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("data driven while clock high");
  timeout_bound_a: assert property (low_cnt <= TIMEOUT_CYC + 16)
    else $error("data line held past timeout");
  pin_reset_a: assert property (rp_cnt > RST_CYC + 8 |-> sda_oe_n && !shutdown && !interrupt_mode
    && !alarm_polarity && fault_queue_sel == 2'h0) else $error("reset pin ignored");
  drive_zero_a: assert property (sda_out == 1'b0) else $error("open drain value not low");
  cover property (interrupt_mode && comp_event);
  cover property ($fell(sda_oe_n));
  cover property (low_cnt == TIMEOUT_CYC);
endmodule
bind tsp_port tsp_port_properties #(.TIMEOUT_CYC(TIMEOUT_CYC), .RST_CYC(RST_CYC)) chk (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .reset_pin_n(reset_pin_n), .comp_hot(comp_hot), .comp_event(comp_event),
  .over_temp_alarm_output(over_temp_alarm_output), .shutdown(shutdown),
  .fault_queue_sel(fault_queue_sel), .interrupt_mode(interrupt_mode),
  .alarm_polarity(alarm_polarity));

// ==== tsp_master.sv ====
// Two-wire bus master model that drives the serial pins.
`timescale 1ns/1ps
module tsp_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam realtime Q = 31.25; // Quarter of a 125 ns bit, far above 6 Hz.
  // Idle bus: both lines released, the clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start, also usable as a repeated start from a low clock.
  task automatic start();
    sda_low <= 1'b0;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b1;
    #Q scl <= 1'b0;
    #Q;
  endtask
  // Stop ends the frame and releases the data line to its pull-up.
  task automatic stop();
    sda_low <= 1'b1;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b0;
    #Q;
  endtask
  // One bit; data changes only while the clock is low.
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    #Q scl <= 1'b1;
    #Q r = sda;
    #Q scl <= 1'b0;
    #Q;
  endtask
  // Byte plus acknowledge slot, most significant bit first.
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic a_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a_in, a_out);
  endtask
endmodule

// ==== test_tsp_port.sv ====
// Self-checking bench for the serial register port.
`timescale 1ns/1ps
`include "tsp_map.vh"
module test_tsp_port;
  localparam logic [7:0] AW = {`TSP_SLAVE_ADDR, 1'b0};
  logic clock, rst_n, reset_pin_n, temp_update, comp_hot, comp_event, ak;
  logic m_low, scl, sda_oe_n, sda_out, alarm, shdn, imode, pol;
  logic [8:0] temp_data;
  logic [1:0] fq;
  logic [7:0] b0, b1;
  logic [15:0] e[4] = '{16'h1900, 16'h0000, 16'h4B00, 16'h5000};
  int n_fail, checked;
  wire sda = (sda_oe_n | sda_out) & !m_low;
  tsp_port #(.TIMEOUT_CYC(200)) dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reset_pin_n(reset_pin_n),
    .temp_data(temp_data), .temp_update(temp_update), .comp_hot(comp_hot),
    .comp_event(comp_event), .over_temp_alarm_output(alarm), .shutdown(shdn),
    .fault_queue_sel(fq), .interrupt_mode(imode), .alarm_polarity(pol));
  tsp_master m (.scl(scl), .sda_low(m_low), .sda(sda));
  // Comparison counted always, reported only on a mismatch.
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write frame: address, pointer, then n data bytes from the top of d.
  task automatic wr(logic [7:0] a, logic [1:0] p, int n, logic [23:0] d);
    logic [7:0] q;
    m.start();
    m.xfer(a, 1'b1, q, ak);
    chk("address ack", a != AW, ak);
    m.xfer({6'h00, p}, 1'b1, q, ak);
    for (int i = 0; i < n; i++) begin
      m.xfer(d[23-8*i -: 8], 1'b1, q, ak);
    end
    m.stop();
  endtask
  // Two-byte read, moving the pointer first when asked.
  task automatic rd(logic setp, logic [1:0] p);
    logic [7:0] q;
    if (setp) begin
      m.start();
      m.xfer(AW, 1'b1, q, ak);
      m.xfer({6'h00, p}, 1'b1, q, ak);
    end
    m.start();
    m.xfer(AW | 8'h01, 1'b1, q, ak);
    m.xfer(8'hFF, 1'b0, b0, ak);
    m.xfer(8'hFF, 1'b1, b1, ak);
    m.stop();
  endtask
  // One-cycle pulse on the alarm event input, then let it settle.
  task automatic fire();
    @(posedge clock) comp_event <= 1'b1;
    @(posedge clock) comp_event <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // Power-up values of every register and of the mode outputs.
  task automatic t_power();
    chk("idle outputs", 16'h0001, {shdn, imode, pol, alarm});
    for (int p = 0; p < 4; p++) begin
      rd(p != 0, p[1:0]);
      chk("power-up reg", e[p], {b0, b1});
    end
    $display("t_power done");
  endtask
  // Config extra bytes, pointer retention and the alarm modes.
  task automatic t_cfg();
    wr(AW, 2'h1, 3, 24'h071A01);
    chk("config fields", 16'h001A, {fq, pol, imode, shdn});
    rd(1'b0, 2'h0);
    chk("config read", 16'h1A1A, {b0, b1});
    fire();
    chk("alarm set", 16'h0000, alarm);
    rd(1'b0, 2'h0);
    chk("alarm cleared", 16'h0001, alarm);
    fire();
    wr(AW, 2'h1, 1, 24'h1B0000);
    chk("shutdown", 16'h0003, {shdn, alarm});
    wr(AW, 2'h1, 1, 24'h000000);
    @(posedge clock) comp_hot <= 1'b1;
    repeat (6) @(posedge clock);
    chk("comparator", 16'h0000, {shdn, alarm});
    @(posedge clock) comp_hot <= 1'b0;
    $display("t_cfg done");
  endtask
  // Limit writes of one and three bytes, low bits read as zero.
  task automatic t_lim();
    wr(AW, 2'h3, 1, 24'h550000);
    rd(1'b0, 2'h0);
    chk("high limit", 16'h5500, {b0, b1});
    wr(AW, 2'h2, 3, 24'h4CFF12);
    rd(1'b0, 2'h0);
    chk("hysteresis", 16'h4C80, {b0, b1});
    $display("t_lim done");
  endtask
  // Temperature ignores writes and holds during a read.
  task automatic t_temp();
    wr(AW, 2'h0, 2, 24'hAABB00);
    temp_data <= 9'h1FF;
    fork
      rd(1'b0, 2'h0);
      begin
        repeat (200) @(posedge clock);
        temp_update <= 1'b1;
        @(posedge clock) temp_update <= 1'b0;
      end
    join
    chk("temperature", 16'h1900, {b0, b1});
    wr(AW + 8'h02, 2'h1, 1, 24'h010000);
    chk("foreign write", 16'h0000, shdn);
    $display("t_temp done");
  endtask
  // Short read leaves the line held low until the timeout frees it.
  task automatic t_hold();
    logic [7:0] q;
    m.start();
    m.xfer(AW | 8'h01, 1'b1, q, ak);
    repeat (20) @(posedge clock);
    chk("line held", 16'h0000, sda_oe_n);
    repeat (240) @(posedge clock);
    chk("timeout release", 16'h0001, sda_oe_n);
    m.stop();
    $display("t_hold done");
  endtask
  // A short pulse is ignored, a full microsecond restores power-up values.
  task automatic t_pin();
    wr(AW, 2'h1, 1, 24'h040000);
    for (int n = 60; n <= 140; n += 80) begin
      @(posedge clock) reset_pin_n <= 1'b0;
      repeat (n) @(posedge clock);
      reset_pin_n <= 1'b1;
      repeat (150) @(posedge clock);
      chk("polarity", n < 125, pol);
    end
    rd(1'b1, 2'h3);
    chk("limit after pin", 16'h5000, {b0, b1});
    $display("t_pin done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // System clock at 125 MHz.
  initial begin
    clock = 1'b0;
    forever #4 clock = !clock;
  end
  // Watchdog well beyond the expected run of some 100 us, kept under 100k cycles.
  initial begin
    #400us;
    n_fail++;
    conclude();
  end
  // Main sequence: reset, load one conversion, then every scenario.
  initial begin
    {rst_n, temp_update, comp_hot, comp_event} = 4'h0;
    reset_pin_n = 1'b1;
    temp_data = 9'h032;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock) temp_update <= 1'b1;
    @(posedge clock) temp_update <= 1'b0;
    repeat (10) @(posedge clock);
    t_power();
    t_cfg();
    t_lim();
    t_temp();
    t_hold();
    t_pin();
    conclude();
  end
endmodule
